/* File: common/esw_pkg.sv */
/*
  Constants and types shared by the status and write-protect block.
  Assumes a 40 MHz system clock that oversamples the serial pins.
*/
package esw_pkg;

  // Clock and write cycle timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_WRITE_NS = 4000000;
  localparam int WRITE_CYCLES = T_WRITE_NS / CLK_PERIOD_NS;
  localparam int TMR_W = 18;
  localparam int SYNC_W = 5;

  //////////////////////////////////////////////////////////////////////////////
  // Opcodes, compared under a mask because bit 3 is a don't care
  localparam logic [7:0] OPC_MASK = 8'hF7;
  localparam logic [7:0] OPC_SET_LATCH = 8'h06;
  localparam logic [7:0] OPC_CLR_LATCH = 8'h04;
  localparam logic [7:0] OPC_STATUS_RD = 8'h05;
  localparam logic [7:0] OPC_STATUS_WR = 8'h01;
  localparam logic [7:0] OPC_ARRAY_WR = 8'h02;

  //////////////////////////////////////////////////////////////////////////////
  // Status register layout
  localparam int ST_BUSY = 0;
  localparam int ST_LATCH = 1;
  localparam int ST_BP_LO = 2;
  localparam int ST_BP_HI = 3;
  localparam int ST_ARM = 7;
  localparam logic [7:0] ST_WRITING = 8'hFF;
  localparam logic [1:0] BP_RESET = 2'h0;
  localparam logic ARM_RESET = 1'b0;

  // Block protect levels and their lower bounds
  localparam logic [1:0] BP_NONE = 2'h0;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [1:0] BP_ALL = 2'h3;
  localparam logic [11:0] ADDR_QUARTER = 12'hC00;
  localparam logic [11:0] ADDR_HALF = 12'h800;

  // Synchroniser bit positions
  localparam int SY_SCK = 0;
  localparam int SY_CS = 1;
  localparam int SY_SI = 2;
  localparam int SY_HOLD = 3;
  localparam int SY_WP = 4;

  typedef enum logic [2:0] {
    PH_OPCODE,
    PH_ADDR_HI,
    PH_ADDR_LO,
    PH_DATA,
    PH_IGNORE
  } esw_phase_e;

  typedef enum logic {
    WK_STATUS,
    WK_ARRAY
  } esw_wkind_e;

endpackage : esw_pkg

/* File: core/esw_sync.sv */
/*
  Two-flop synchroniser, one per pin bit.
  Assumes its inputs are asynchronous to CLK_SYS.
*/
`timescale 1ns/1ps
`default_nettype none
module esw_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      logic meta;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta <= 1'b1;
          q[i] <= 1'b1;
        end else if (ce) begin
          meta <= d[i];
          q[i] <= meta;
        end
      end
    end
  endgenerate

endmodule : esw_sync
`default_nettype wire

/* File: core/esw_wr_timer.sv */
/*
  Self-timed internal write cycle: busy from start until the count runs out.
  Assumes start is a one-cycle pulse on CLK_SYS.
*/
`timescale 1ns/1ps
`default_nettype none
module esw_wr_timer #(
  parameter int CYCLES = esw_pkg::WRITE_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Control
  input wire logic start,
  output logic busy,
  output logic done
);
  import esw_pkg::*;

  logic [TMR_W-1:0] cnt;
  wire last = (cnt == TMR_W'(1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (ce) begin
      done <= busy & last;
      if (start && !busy) begin
        cnt <= TMR_W'(CYCLES);
        busy <= 1'b1;
      end else if (busy) begin
        cnt <= cnt - TMR_W'(1);
        busy <= !last;
      end
    end
  end

endmodule : esw_wr_timer
`default_nettype wire

/* File: core/esw_protect.sv */
/*
  Status register and write protection of a 4096-byte serial EEPROM,
  with the SPI front end needed to run its status commands.
  Assumes SPI pins arrive asynchronously and SCK is well below CLK_SYS/4;
  the array sequencer sits outside and acts on ARRAY_WR_START.
*/
// Functional notes
// - Hardware protect needs pin low and arm set
// - Hardware protect blocks block bits and arm
// - Hardware protect never restricts array writes
// - Suspend pin freezes and later resumes sequence
// - Suspend pin tied high never suspends
// - Status write needs latch and no protect
// - Bit 0 busy; busy accepts only status read
// - Bit 1 latch; zero blocks all writes
// - Latch clears at reset, set by command
// - Bits 2,3 block protect, shipped zero
// - Bits 4 to 6 read zero, not kept
// - Bit 7 arm; no clearing while pin low
// - All status bits read one while writing
// - Block protect decodes quarter, half, all
// - Protected block read-only; others need latch
// - Everything transferred most significant bit first
// - Sample input on rise, drive output on fall
// - Latch clears after disable or completed write
`timescale 1ns/1ps
`default_nettype none
module esw_protect #(
  parameter int WRITE_CYCLES = esw_pkg::WRITE_CYCLES
) (
  // System
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic CE,
  // Serial pins
  input wire logic CS_N,
  input wire logic SCK,
  input wire logic SI,
  output logic SO,
  output logic SO_OE,
  // Control pins
  input wire logic WP_N,
  input wire logic HOLD_N,
  // Array write hand-off
  output logic ARRAY_WR_START,
  output logic [11:0] ARRAY_WR_ADDR,
  // State
  output logic BUSY,
  output logic HW_PROTECT,
  output logic [7:0] STATUS
);
  import esw_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and edge detection
  logic [SYNC_W-1:0] pin_s;
  logic sck_q;
  logic cs_q;

  esw_sync #(.W(SYNC_W)) u_sync (
    .clk(CLK_SYS),
    .rst_n(RESETN),
    .ce(CE),
    .d({WP_N, HOLD_N, SI, CS_N, SCK}),
    .q(pin_s)
  );

  wire sck_s = pin_s[SY_SCK];
  wire cs_s = pin_s[SY_CS];
  wire si_s = pin_s[SY_SI];
  wire hold_s = pin_s[SY_HOLD];
  wire wp_s = pin_s[SY_WP];

  // Clock edges are ignored while suspended; hold only moves with SCK low
  wire live = !cs_s && hold_s;
  wire sck_rise = live && sck_s && !sck_q;
  wire sck_fall = live && !sck_s && sck_q;
  wire cs_fall = !cs_s && cs_q;
  wire cs_rise = cs_s && !cs_q;

  ////////////////////////////////////////////////////////////////////////////
  // Protection state
  logic latch;
  logic [1:0] bp;
  logic arm;
  logic busy;
  logic tmr_done;
  esw_wkind_e wkind;
  logic [7:0] sr_pending;

  wire hw_prot = arm && !wp_s;
  wire [7:0] status_view = busy ? ST_WRITING :
                           {arm, 3'h0, bp, latch, 1'b0};

  ////////////////////////////////////////////////////////////////////////////
  // Serial receive
  esw_phase_e phase;
  logic [2:0] bit_cnt;
  logic [6:0] shift_in;
  logic [7:0] opcode;
  logic [11:0] addr;
  logic got_data;
  logic rd_active;

  wire [7:0] rx_byte = {shift_in, si_s};
  wire byte_end = sck_rise && (bit_cnt == 3'h7);
  wire [7:0] opc_m = rx_byte & OPC_MASK;
  wire is_rd = (opc_m == OPC_STATUS_RD);
  wire is_wr_sr = (opc_m == OPC_STATUS_WR);
  wire is_wr_arr = (opc_m == OPC_ARRAY_WR);
  wire [7:0] op_m = opcode & OPC_MASK;
  // A command whose opcode lands while busy must not fire once busy drops
  wire [7:0] opc_keep = (busy && !is_rd) ? 8'h00 : rx_byte;

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      sck_q <= 1'b0;
      cs_q <= 1'b1;
    end else if (CE) begin
      sck_q <= sck_s;
      cs_q <= cs_s;
    end
  end

  // Counters only advance on live edges, so a suspend leaves them intact
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      bit_cnt <= 3'h0;
      shift_in <= 7'h00;
    end else if (CE) begin
      if (cs_fall) begin
        bit_cnt <= 3'h0;
      end else if (sck_rise) begin
        bit_cnt <= bit_cnt + 3'h1;
        shift_in <= rx_byte[6:0];
      end
    end
  end

  // Busy device decodes only the status read; the rest falls to ignore
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      phase <= PH_OPCODE;
      opcode <= 8'h00;
      addr <= 12'h000;
      got_data <= 1'b0;
      rd_active <= 1'b0;
      sr_pending <= 8'h00;
    end else if (CE) begin
      if (cs_fall) begin
        phase <= PH_OPCODE;
        opcode <= 8'h00;
        got_data <= 1'b0;
        rd_active <= 1'b0;
      end else if (byte_end) begin
        case (phase)
          PH_OPCODE: begin
            opcode <= opc_keep;
            rd_active <= is_rd;
            if (busy && !is_rd) begin
              phase <= PH_IGNORE;
            end else if (is_wr_arr) begin
              phase <= PH_ADDR_HI;
            end else if (is_wr_sr) begin
              phase <= PH_DATA;
            end else begin
              phase <= PH_IGNORE;
            end
          end
          PH_ADDR_HI: begin
            addr[11:8] <= rx_byte[3:0];
            phase <= PH_ADDR_LO;
          end
          PH_ADDR_LO: begin
            addr[7:0] <= rx_byte;
            phase <= PH_DATA;
          end
          PH_DATA: begin
            got_data <= 1'b1;
            if (!got_data) begin
              sr_pending <= rx_byte;
            end
          end
          default: begin
            phase <= PH_IGNORE;
          end
        endcase
      end else if (cs_rise) begin
        rd_active <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command completion on chip select rise
  wire whole = (bit_cnt == 3'h0) && !busy;
  wire do_set = cs_rise && whole && (phase == PH_IGNORE) &&
                (op_m == OPC_SET_LATCH);
  wire do_clr = cs_rise && whole && (phase == PH_IGNORE) &&
                (op_m == OPC_CLR_LATCH);
  wire in_block = (bp == BP_ALL) ||
                  ((bp == BP_HALF) && (addr >= ADDR_HALF)) ||
                  ((bp == BP_QUARTER) && (addr >= ADDR_QUARTER));
  wire start_sr = cs_rise && whole && got_data && (op_m == OPC_STATUS_WR) &&
                  latch && !hw_prot;
  wire start_arr = cs_rise && whole && got_data && (op_m == OPC_ARRAY_WR) &&
                   latch && !in_block;
  wire next_arm = (arm && !wp_s) ? 1'b1 : sr_pending[ST_ARM];
  wire sr_commit = tmr_done && (wkind == WK_STATUS) && !hw_prot;

  esw_wr_timer #(.CYCLES(WRITE_CYCLES)) u_timer (
    .clk(CLK_SYS),
    .rst_n(RESETN),
    .ce(CE),
    .start(start_sr || start_arr),
    .busy(busy),
    .done(tmr_done)
  );

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      latch <= 1'b0;
      bp <= BP_RESET;
      arm <= ARM_RESET;
      wkind <= WK_STATUS;
    end else if (CE) begin
      if (start_sr) begin
        wkind <= WK_STATUS;
      end else if (start_arr) begin
        wkind <= WK_ARRAY;
      end
      if (sr_commit) begin
        bp <= {sr_pending[ST_BP_HI], sr_pending[ST_BP_LO]};
        arm <= next_arm;
      end
      if (tmr_done || do_clr) begin
        latch <= 1'b0;
      end else if (do_set) begin
        latch <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial transmit of the status byte, repeated while clocked
  logic [2:0] out_cnt;
  logic [6:0] out_shift;

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      out_cnt <= 3'h0;
      out_shift <= 7'h00;
      SO <= 1'b0;
      SO_OE <= 1'b0;
    end else if (CE) begin
      SO_OE <= rd_active && live;
      if (cs_fall) begin
        out_cnt <= 3'h0;
      end else if (sck_fall && rd_active) begin
        out_cnt <= out_cnt + 3'h1;
        if (out_cnt == 3'h0) begin
          SO <= status_view[7];
          out_shift <= status_view[6:0];
        end else begin
          SO <= out_shift[6];
          out_shift <= {out_shift[5:0], 1'b0};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered state outputs
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      ARRAY_WR_START <= 1'b0;
      ARRAY_WR_ADDR <= 12'h000;
      BUSY <= 1'b0;
      HW_PROTECT <= 1'b0;
      STATUS <= 8'h00;
    end else if (CE) begin
      ARRAY_WR_START <= start_arr;
      if (start_arr) begin
        ARRAY_WR_ADDR <= addr;
      end
      BUSY <= busy;
      HW_PROTECT <= hw_prot;
      STATUS <= status_view;
    end
  end

endmodule : esw_protect
`default_nettype wire

/* File: test/esw_properties.sv */
/* Port assertions for the status and write-protect block.
   Assumes binding to esw_protect, all in the CLK_SYS domain. */
`timescale 1ns/1ps
`default_nettype none
module esw_properties
  import esw_pkg::*;
#(
  parameter int WRITE_CYCLES = esw_pkg::WRITE_CYCLES
) (
  // System
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic CE,
  // Serial and control pins
  input wire logic CS_N,
  input wire logic SCK,
  input wire logic SI,
  input wire logic SO,
  input wire logic SO_OE,
  input wire logic WP_N,
  input wire logic HOLD_N,
  // Results
  input wire logic ARRAY_WR_START,
  input wire logic [11:0] ARRAY_WR_ADDR,
  input wire logic BUSY,
  input wire logic HW_PROTECT,
  input wire logic [7:0] STATUS
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  function automatic logic blk(input logic [1:0] bp, input logic [11:0] a);
    return bp == BP_ALL || (bp == BP_HALF && a >= ADDR_HALF) ||
      (bp == BP_QUARTER && a >= ADDR_QUARTER);
  endfunction : blk
  ////////////////////////////////////////
  busy_ones_a: assert property (BUSY && $past(BUSY) |-> STATUS == ST_WRITING)
    else $error("status not all ones while busy");
  ready_bit_a: assert property (!BUSY && !$past(BUSY) |-> !STATUS[ST_BUSY])
    else $error("busy bit set while idle");
  spare_bits_a: assert property (!BUSY && !$past(BUSY) |-> STATUS[6:4] == 3'h0)
    else $error("spare status bits not zero");
  pin_high_a: assert property (WP_N [*6] |-> !HW_PROTECT)
    else $error("protect active with pin high");
  arm_clear_a: assert property ((!STATUS[ST_ARM] && !BUSY) [*2] |-> !HW_PROTECT)
    else $error("protect active with arm clear");
  block_ok_a: assert property (ARRAY_WR_START |-> !blk($past(STATUS[3:2]), ARRAY_WR_ADDR))
    else $error("array write inside protected block");
  addr_hold_a: assert property ($changed(ARRAY_WR_ADDR) |-> ARRAY_WR_START)
    else $error("write address moved without start");
  hold_quiet_a: assert property (!HOLD_N [*5] |-> !SO_OE)
    else $error("output driven during suspend");
  idle_quiet_a: assert property (CS_N [*5] |-> !SO_OE)
    else $error("output driven while deselected");
  c_busy: cover property ($rose(BUSY));
  c_write: cover property (ARRAY_WR_START);
  c_protect: cover property ($rose(HW_PROTECT));
  c_read: cover property (SO_OE);
endmodule : esw_properties
bind esw_protect esw_properties #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (
  .CLK_SYS(CLK_SYS), .RESETN(RESETN), .CE(CE), .CS_N(CS_N), .SCK(SCK), .SI(SI),
  .SO(SO), .SO_OE(SO_OE), .WP_N(WP_N), .HOLD_N(HOLD_N),
  .ARRAY_WR_START(ARRAY_WR_START), .ARRAY_WR_ADDR(ARRAY_WR_ADDR), .BUSY(BUSY),
  .HW_PROTECT(HW_PROTECT), .STATUS(STATUS));
`default_nettype wire

/* File: test/esw_spi_master.sv */
/* SPI master model, mode 0, for the status block.
   Assumes the bench calls frame; paced by the bench clock. */
`timescale 1ns/1ps
`default_nettype none
module esw_spi_master (
  // Pacing clock
  input wire logic clk,
  // Serial pins
  input wire logic so,
  input wire logic so_oe,
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic hold_n
);
  logic so_last = 1'b0;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
  end
  // Half an SCK period: 4 cycles, 200 ns per bit
  task automatic half();
    repeat (4) @(posedge clk);
  endtask : half
  ////////////////////////////////////////
  // Suspend with stray clocks the device must ignore
  task automatic pause();
    // Let the last falling clock edge be seen before suspending
    half();
    hold_n <= 1'b0;
    repeat (2) begin
      half();
      sck <= 1'b1;
      si <= ~si;
      half();
      sck <= 1'b0;
    end
    half();
    hold_n <= 1'b1;
  endtask : pause
  task automatic frame(input logic [7:0] b[$], input int hold_at, output logic [7:0] rx);
    @(posedge clk);
    cs_n <= 1'b0;
    half();
    foreach (b[k]) begin
      for (int i = 0; i < 8; i++) begin
        if (k * 8 + i == hold_at) pause();
        si <= b[k][7 - i];
        half();
        sck <= 1'b1;
        half();
        // Undriven line reads as the inverse of the last bit
        so_last = so_oe ? so : ~so_last;
        rx[7 - i] = so_last;
        sck <= 1'b0;
      end
    end
    half();
    cs_n <= 1'b1;
    si <= ~si;
    repeat (12) @(posedge clk);
  endtask : frame
endmodule : esw_spi_master
`default_nettype wire

/* File: test/tb.sv */
/* Bench for the status and write-protect block with a bit-level model.
   Assumes the SPI master model drives the serial pins. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import esw_pkg::*;
  localparam int WC = 200;
  logic clk_sys, resetn, wp_n, latch, arm, ce;
  logic [1:0] bp;
  logic [7:0] rx;
  logic [11:0] last_addr;
  logic [11:0] adr[4] = '{12'h7FF, 12'h800, 12'hBFF, 12'hC00};
  int n_errors, checks, n_pulse, seed;
  wire logic cs_n, sck, si, hold_n, so, so_oe, array_wr_start, busy, hw_protect;
  wire logic [11:0] array_wr_addr;
  wire logic [7:0] status;
  esw_protect #(.WRITE_CYCLES(WC)) i_dut (.CLK_SYS(clk_sys), .RESETN(resetn),
    .CE(ce), .CS_N(cs_n), .SCK(sck), .SI(si), .SO(so), .SO_OE(so_oe), .WP_N(wp_n),
    .HOLD_N(hold_n), .ARRAY_WR_START(array_wr_start), .ARRAY_WR_ADDR(array_wr_addr),
    .BUSY(busy), .HW_PROTECT(hw_protect), .STATUS(status));
  esw_spi_master i_master (.clk(clk_sys), .so(so), .so_oe(so_oe), .cs_n(cs_n),
    .sck(sck), .si(si), .hold_n(hold_n));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (array_wr_start === 1'b1) begin
      n_pulse++;
      last_addr = array_wr_addr;
    end
  end
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  task automatic wait_busy(input logic v, input int n);
    for (int i = 0; i < n && busy !== v; i++) @(posedge clk_sys);
    chk("busy", v, busy);
  endtask : wait_busy
  task automatic cmd(input logic [7:0] op);
    i_master.frame('{op}, -1, rx);
    latch = op == OPC_SET_LATCH;
  endtask : cmd
  task automatic status_read_cmd(input int h);
    i_master.frame('{OPC_STATUS_RD, 8'h00}, h, rx);
    chk("status_read", {arm, 3'h0, bp, latch, 1'b0}, rx);
    chk("status", {arm, 3'h0, bp, latch, 1'b0}, status);
  endtask : status_read_cmd
  task automatic status_write_cmd(input logic [7:0] d);
    logic ok;
    ok = latch && !(arm && !wp_n);
    i_master.frame('{OPC_STATUS_WR, d}, -1, rx);
    if (ok) begin
      wait_busy(1'b1, 20);
      chk("busy_ones", ST_WRITING, status);
      i_master.frame('{OPC_SET_LATCH}, -1, rx);
      wait_busy(1'b0, 400);
      bp = d[3:2];
      arm = d[7];
      latch = 1'b0;
    end
    else chk("busy", 0, busy);
    status_read_cmd(-1);
  endtask : status_write_cmd
  task automatic awr(input logic [11:0] a);
    int n0;
    logic blk;
    n0 = n_pulse;
    blk = bp == 3 || (bp == 2 && a >= 12'h800) || (bp == 1 && a >= 12'hC00);
    cmd(OPC_SET_LATCH);
    i_master.frame('{OPC_ARRAY_WR, {4'h0, a[11:8]}, a[7:0], 8'h5A}, -1, rx);
    chk("wr_pulse", !blk, n_pulse - n0);
    if (!blk) chk("wr_addr", a, last_addr);
    // Fixed wait of WC cycles in place of polling, then busy must drop within 8 cycles
    if (!blk) repeat (WC) @(posedge clk_sys);
    wait_busy(1'b0, 8);
    cmd(OPC_CLR_LATCH);
  endtask : awr
  initial begin
    #1500000;
    n_errors++;
    wrap_up();
  end
  initial begin
    seed = 32'h6f31e42b;
    {n_errors, checks, n_pulse} = '0;
    {resetn, wp_n, latch, arm, bp} = 6'h00;
    ce = 1'b1;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk("status", 8'h00, status);
    $display("test reset finished");
    // Frozen device must ignore a whole command
    ce <= 1'b0;
    cmd(OPC_SET_LATCH);
    ce <= 1'b1;
    latch = 1'b0;
    status_read_cmd(-1);
    status_write_cmd(8'h0C);
    cmd(OPC_SET_LATCH);
    status_read_cmd(-1);
    cmd(OPC_CLR_LATCH);
    status_read_cmd(-1);
    $display("test latch finished");
    for (int l = 0; l < 4; l++) begin
      cmd(OPC_SET_LATCH);
      status_write_cmd({1'b0, 3'($random(seed)), 2'(l), 2'h0});
      status_read_cmd(3 + 4 * l);
      foreach (adr[j]) awr(adr[j]);
      awr(12'($random(seed)));
    end
    $display("test levels finished");
    chk("hw_protect", 0, hw_protect);
    cmd(OPC_SET_LATCH);
    status_write_cmd(8'h80);
    wp_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chk("hw_protect", 1, hw_protect);
    cmd(OPC_SET_LATCH);
    status_write_cmd(8'h0C);
    awr(12'h123);
    wp_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk("hw_protect", 0, hw_protect);
    cmd(OPC_SET_LATCH);
    status_write_cmd(8'h00);
    $display("test protect finished");
    wrap_up();
  end
endmodule : tb
`default_nettype wire
